// *** include/cfei_regs.svh ***
// Register offsets, field positions and reset values of the CAN filter
// event and interrupt block.
// Assumes an 8-bit register port with byte-wide offsets.
`ifndef CFEI_REGS_SVH
`define CFEI_REGS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define CFEI_OFS_F0_ID_HI 8'h20
`define CFEI_OFS_FON_LOW 8'h70
`define CFEI_OFS_FON_HIGH 8'h71
`define CFEI_OFS_MIE_LOW 8'h72
`define CFEI_OFS_EXTRA_IE 8'h73
`define CFEI_OFS_MFLAG_LOW 8'h74
`define CFEI_OFS_EXTRA_IF 8'h75

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define CFEI_MKSEL_MSB 7
`define CFEI_MKSEL_LSB 5
`define CFEI_ID_HI_MSB 4
`define CFEI_ID_HI_LSB 0
`define CFEI_FON_HIGH_PAD 4'hf
`define CFEI_BIT_THERMAL 12
`define CFEI_BIT_MEM_CORR 13
`define CFEI_BIT_XCVR_ERR 14
`define CFEI_BIT_WAKE 15

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define CFEI_RST_BYTE 8'h00
`define CFEI_RST_FON 12'h000
`define CFEI_RST_VEC 16'h0000
`define CFEI_RD_UNMAPPED 8'h00

`endif

// *** include/cfei_pkg.sv ***
// Shared types of the CAN filter event and interrupt block.
// Assumes cfei_regs.svh supplies the numeric constants.
`default_nettype none

package cfei_pkg;
  typedef logic [7:0] cfei_byte_t;
  typedef logic [15:0] cfei_vec_t;
  typedef logic [2:0] cfei_mask_sel_t;
  typedef logic [4:0] cfei_id_hi_t;
endpackage : cfei_pkg

`default_nettype wire

// *** design/cfei_pin_sync.sv ***
// Three-stage synchroniser for one level arriving from a pin.
// Assumes the pin may change at any time relative to ref_clk.
`default_nettype none

module cfei_pin_sync
  import cfei_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Pin and clean level
  input wire logic pin_in,
  output logic level_out
);
  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  // The output moves only when the last two stages agree, so one
  // stray sample never reaches the event logic.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule : cfei_pin_sync

`default_nettype wire

// *** design/cfei_flag_cell.sv ***
// One sticky event flag with a clear input.
// Assumes set and clear are single-cycle terms on ref_clk.
`default_nettype none

module cfei_flag_cell
  import cfei_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Event and clear
  input wire logic set_evt,
  input wire logic clr,
  // Flag
  output logic flag
);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

  chk_set_over_clr: assert property (
    @(posedge ref_clk) disable iff (srst)
    set_evt |=> flag) else $error("event lost against clear");
endmodule : cfei_flag_cell

`default_nettype wire

// *** design/cfei_top.sv ***
// Filter-match and extra event flags, their enables, the interrupt line
// and filter 0 top identifier byte with its mask select.
// Assumes an 8-bit register port driven by the serial host front end,
// and one-cycle event pulses from the filter and transceiver logic.
//
// What this block does
// - Enabled wakeup event leaves stop mode and pulls interrupt low.
// - Enabled transceiver error pulls the interrupt line low.
// - Enabled memory correction event pulls the interrupt line low.
// - Enabled thermal shutdown event pulls the interrupt line low.
// - Extra enable: filter 8-11 enables bits 0-3, events bits 7-4.
// - Enabled filter match sets its flag; filters 0-7 in low flags.
// - Reading the low flag register clears all its flags.
// - Host writes to both flag registers are ignored.
// - Filters 8-11 flags in extra flag bits 0-3, clear on read.
// - Wakeup flag sets regardless of enable; interrupt needs enable.
// - Transceiver flag clears only after faults gone and fault reg clear.
// - Memory correction flag sets on correction, clears on read.
// - Thermal flag sets on shutdown entry and exit, clears on read.
// - Filter registers writable only in reset mode, else read-only.
// - Three-bit select in filter 0 byte bits 7-5 picks one of 8 masks.
// - Filter 0 top byte resets zero: select high, five ID bits low.
// - Filters 0-7 match interrupt enables sit in a separate register.
// - Mask bit 0 compares the identifier bit, 1 ignores it.
// - Each filter has an enable; disabled filters never set flags.
`include "cfei_regs.svh"
`default_nettype none

module cfei_top
  import cfei_pkg::*;
#(
  parameter int NUM_FILTERS = 12,
  parameter int NUM_MASKS = 8
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port from the serial host front end
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Operating mode
  input wire logic reset_mode,
  input wire logic stop_mode,
  output logic stop_exit,
  // Filter compare datapath
  input wire logic [11:0] rx_hit,
  input wire logic [4:0] rx_id_hi,
  input wire logic [39:0] mask_hi_bank,
  output logic [11:0] filter_on,
  output logic [2:0] filter0_mask_pick,
  // Event sources
  input wire logic wake_pin,
  input wire logic xcvr_err_evt,
  input wire logic xcvr_fault_pending,
  input wire logic mem_corr_evt,
  input wire logic thermal_sd,
  // Interrupt pin
  output logic irq_out_low
);

  // -------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------
  // The register layout fixes twelve filters and eight masks.
  if (NUM_FILTERS != 12 || NUM_MASKS != 8) begin : g_bad_cfg
    $error("cfei_top supports exactly 12 filters and 8 masks");
  end

  // -------------------------------------------------------------------
  // Configuration registers
  // -------------------------------------------------------------------
  cfei_byte_t match_irq_en_low_reg;
  cfei_byte_t extra_ie_reg;
  cfei_id_hi_t filter0_id_hi_reg;
  cfei_mask_sel_t filter0_mask_pick_reg;
  logic [11:0] filter_on_reg;
  logic wr_f0;
  logic wr_fon_low;
  logic wr_fon_high;
  logic wr_mie_low;
  logic wr_extra_ie;
  logic rd_low;
  logic rd_ext;

  assign wr_f0 = reg_wr && reg_addr == `CFEI_OFS_F0_ID_HI;
  assign wr_fon_low = reg_wr && reg_addr == `CFEI_OFS_FON_LOW;
  assign wr_fon_high = reg_wr && reg_addr == `CFEI_OFS_FON_HIGH;
  assign wr_mie_low = reg_wr && reg_addr == `CFEI_OFS_MIE_LOW;
  assign wr_extra_ie = reg_wr && reg_addr == `CFEI_OFS_EXTRA_IE;
  assign rd_low = reg_rd && reg_addr == `CFEI_OFS_MFLAG_LOW;
  assign rd_ext = reg_rd && reg_addr == `CFEI_OFS_EXTRA_IF;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      filter0_id_hi_reg <= cfei_id_hi_t'(`CFEI_RST_BYTE);
      filter0_mask_pick_reg <= cfei_mask_sel_t'(`CFEI_RST_BYTE);
    end else if (wr_f0 && reset_mode) begin
      filter0_mask_pick_reg <= reg_wdata[`CFEI_MKSEL_MSB:`CFEI_MKSEL_LSB];
      filter0_id_hi_reg <= reg_wdata[`CFEI_ID_HI_MSB:`CFEI_ID_HI_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      filter_on_reg <= `CFEI_RST_FON;
    end else if (reset_mode) begin
      if (wr_fon_low) begin
        filter_on_reg[7:0] <= reg_wdata;
      end else if (wr_fon_high) begin
        filter_on_reg[11:8] <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      match_irq_en_low_reg <= `CFEI_RST_BYTE;
      extra_ie_reg <= `CFEI_RST_BYTE;
    end else if (wr_mie_low) begin
      match_irq_en_low_reg <= reg_wdata;
    end else if (wr_extra_ie) begin
      extra_ie_reg <= reg_wdata;
    end
  end

  assign filter_on = filter_on_reg;
  assign filter0_mask_pick = filter0_mask_pick_reg;

  // -------------------------------------------------------------------
  // Filter 0 top-byte compare
  // -------------------------------------------------------------------
  cfei_id_hi_t sel_mask_hi;
  logic f0_top_ok;

  assign sel_mask_hi = mask_hi_bank[filter0_mask_pick_reg * 5 +: 5];
  assign f0_top_ok =
    ((rx_id_hi ^ filter0_id_hi_reg) & ~sel_mask_hi) == 5'h00;

  // -------------------------------------------------------------------
  // Event sources
  // -------------------------------------------------------------------
  logic wake_level;
  logic wake_level_d;
  logic wake_evt;
  logic thermal_d;
  logic thermal_evt;
  logic [11:0] match_evt;
  logic [11:0] hit_in;

  cfei_pin_sync u_wake_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_in(wake_pin),
    .level_out(wake_level)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_level_d <= 1'b0;
      thermal_d <= 1'b0;
    end else begin
      wake_level_d <= wake_level;
      thermal_d <= thermal_sd;
    end
  end

  assign wake_evt = wake_level && !wake_level_d;
  assign thermal_evt = thermal_sd != thermal_d;
  // Filter 0 also needs its top byte to agree with the selected mask.
  assign hit_in = {rx_hit[11:1], rx_hit[0] && f0_top_ok};
  assign match_evt = hit_in & filter_on_reg;

  // -------------------------------------------------------------------
  // Sticky flags
  // -------------------------------------------------------------------
  cfei_vec_t flag_set;
  cfei_vec_t flag_clr;
  cfei_vec_t flags;
  cfei_vec_t irq_en;

  assign flag_set = {wake_evt, xcvr_err_evt, mem_corr_evt, thermal_evt,
                     match_evt};
  assign flag_clr = {rd_ext, !xcvr_fault_pending, rd_ext, rd_ext,
                     {4{rd_ext}}, {8{rd_low}}};
  assign irq_en = {extra_ie_reg, match_irq_en_low_reg};

  for (genvar i = 0; i < 16; i++) begin : g_flag
    cfei_flag_cell u_cell (
      .ref_clk(ref_clk),
      .srst(srst),
      .set_evt(flag_set[i]),
      .clr(flag_clr[i]),
      .flag(flags[i])
    );
  end

  // -------------------------------------------------------------------
  // Interrupt line and stop-mode exit
  // -------------------------------------------------------------------
  logic irq_any;

  assign irq_any = |(flags & irq_en);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_out_low <= 1'b1;
    end else begin
      irq_out_low <= !irq_any;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stop_exit <= 1'b0;
    end else begin
      stop_exit <= wake_evt && irq_en[`CFEI_BIT_WAKE] && stop_mode;
    end
  end

  // -------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------
  cfei_byte_t rd_next;

  always_comb begin
    if (reg_addr == `CFEI_OFS_F0_ID_HI) begin
      rd_next = {filter0_mask_pick_reg, filter0_id_hi_reg};
    end else if (reg_addr == `CFEI_OFS_FON_LOW) begin
      rd_next = filter_on_reg[7:0];
    end else if (reg_addr == `CFEI_OFS_FON_HIGH) begin
      rd_next = {`CFEI_FON_HIGH_PAD, filter_on_reg[11:8]};
    end else if (reg_addr == `CFEI_OFS_MIE_LOW) begin
      rd_next = match_irq_en_low_reg;
    end else if (reg_addr == `CFEI_OFS_EXTRA_IE) begin
      rd_next = extra_ie_reg;
    end else if (reg_addr == `CFEI_OFS_MFLAG_LOW) begin
      rd_next = flags[7:0];
    end else if (reg_addr == `CFEI_OFS_EXTRA_IF) begin
      rd_next = flags[15:8];
    end else begin
      rd_next = `CFEI_RD_UNMAPPED;
    end
  end

  // Read data is captured before the read-clear lands, so the host sees
  // the flags that the read is about to drop.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= `CFEI_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_next;
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence s_low_read_quiet;
    rd_low && match_evt[7:0] == 8'h00;
  endsequence

  sequence s_ext_read;
    reg_rd ##0 reg_addr == `CFEI_OFS_EXTRA_IF;
  endsequence

  chk_irq_pair_low: assert property (
    @(posedge ref_clk) disable iff (srst)
    irq_any |=> !irq_out_low) else $error("irq not asserted");
  chk_irq_release: assert property (
    @(posedge ref_clk) disable iff (srst)
    !irq_any |=> irq_out_low) else $error("irq not released");
  chk_wake_exit: assert property (
    @(posedge ref_clk) disable iff (srst)
    wake_evt && extra_ie_reg[7] && stop_mode |=> stop_exit)
    else $error("no stop exit on wake");
  chk_low_read_clr: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_low_read_quiet |=> flags[7:0] == 8'h00)
    else $error("low flags survived read");
  chk_ext_read_clr: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_ext_read ##0 flag_set[11:8] == 4'h0 |=> flags[11:8] == 4'h0)
    else $error("high filter flags survived read");
  chk_flag_wr_ign: assert property (
    @(posedge ref_clk) disable iff (srst)
    reg_wr && !reg_rd && flag_set[11:0] == 12'h000 |=>
    flags[11:0] == $past(flags[11:0])) else $error("flag moved on write");
  chk_xcvr_hold: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_ext_read ##0 flags[14] && xcvr_fault_pending |=> flags[14])
    else $error("xcvr flag cleared by read");
  chk_f0_locked: assert property (
    @(posedge ref_clk) disable iff (srst)
    wr_f0 && !reset_mode |=> $stable(filter0_mask_pick_reg) &&
    $stable(filter0_id_hi_reg)) else $error("filter written in normal");
  chk_fon_locked: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_fon_low || wr_fon_high) && !reset_mode |=> $stable(filter_on_reg))
    else $error("filter enables written in normal");
  chk_thermal_edge: assert property (
    @(posedge ref_clk) disable iff (srst)
    thermal_sd != thermal_d |=> flags[12])
    else $error("thermal edge missed");
  chk_wake_flag: assert property (
    @(posedge ref_clk) disable iff (srst)
    wake_evt |=> flags[`CFEI_BIT_WAKE])
    else $error("wake flag not set");
  chk_filter_off: assert property (
    @(posedge ref_clk) disable iff (srst)
    1'b1 |=> (flags[11:0] & ~$past(flags[11:0]) & ~$past(filter_on_reg)) ==
    12'h000) else $error("disabled filter set flag");
  chk_exie_layout: assert property (
    @(posedge ref_clk) disable iff (srst)
    reg_rd && reg_addr == `CFEI_OFS_EXTRA_IE |=>
    reg_rdata == $past(extra_ie_reg)) else $error("extra enable readback");
endmodule : cfei_top

`default_nettype wire

// *** verif/cfei_host_model.sv ***
// Host-side register master model for the filter event block.
// Assumes the register port takes a strobe on the rising edge of ref_clk.
`default_nettype none

module cfei_host_model
  import cfei_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Idle bus
  // ---------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // ---------------------------------------------------------------
  // Single-byte accesses
  // ---------------------------------------------------------------
  // Released lines show the inverse, so a stale value never decodes.
  task automatic wr(input cfei_byte_t addr, input cfei_byte_t data);
    @(negedge ref_clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask : wr

  task automatic rd(input cfei_byte_t addr, output cfei_byte_t data);
    @(negedge ref_clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    data = reg_rdata;
  endtask : rd
endmodule : cfei_host_model

`default_nettype wire

// *** verif/cfei_top_tb.sv ***
// Self-checking bench for the filter event and interrupt block.
// Assumes the host model drives the register port; events come from here.
`default_nettype none

`define CHK(what, exp, got) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("BAD %s exp %h got %h", what, exp, got); \
  end \
end

module cfei_top_tb
  import cfei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic ref_clk, srst, reg_wr, reg_rd, reset_mode, stop_mode, stop_exit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] rx_hit, filter_on;
  logic [4:0] rx_id_hi;
  logic [39:0] mask_hi_bank;
  logic [2:0] filter0_mask_pick;
  logic wake_pin, xcvr_err_evt, xcvr_fault_pending, mem_corr_evt;
  logic thermal_sd, irq_out_low;
  int mismatches = 0;
  int n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  cfei_top uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reset_mode(reset_mode), .stop_mode(stop_mode),
    .stop_exit(stop_exit), .rx_hit(rx_hit), .rx_id_hi(rx_id_hi),
    .mask_hi_bank(mask_hi_bank), .filter_on(filter_on),
    .filter0_mask_pick(filter0_mask_pick), .wake_pin(wake_pin),
    .xcvr_err_evt(xcvr_err_evt), .xcvr_fault_pending(xcvr_fault_pending),
    .mem_corr_evt(mem_corr_evt), .thermal_sd(thermal_sd),
    .irq_out_low(irq_out_low));

  cfei_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic rchk(input cfei_byte_t a, input cfei_byte_t e,
                      input string nm);
    cfei_byte_t v;
    host.rd(a, v);
    `CHK(nm, e, v)
  endtask : rchk

  // The interrupt trails its event by two edges; three leaves margin.
  task automatic irq_chk(input logic e, input string nm);
    repeat (3) @(negedge ref_clk);
    `CHK(nm, e, irq_out_low)
  endtask : irq_chk

  task automatic pulse_hit(input logic [11:0] h);
    @(negedge ref_clk);
    rx_hit = h;
    @(negedge ref_clk);
    rx_hit = 12'h000;
  endtask : pulse_hit

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_vals();
    cfei_byte_t ad[8] = '{8'h20, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74,
                          8'h75, 8'h10};
    cfei_byte_t ex[8] = '{8'h00, 8'h00, 8'hf0, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00};
    `CHK("irq at reset", 1'b1, irq_out_low)
    for (int i = 0; i < 8; i++) begin
      rchk(ad[i], ex[i], "reset value");
    end
  endtask : t_reset_vals

  task automatic t_lock();
    reset_mode = 1'b0;
    host.wr(8'h20, 8'hab);
    rchk(8'h20, 8'h00, "locked f0 byte");
    host.wr(8'h70, 8'hff);
    `CHK("locked enables", 12'h000, filter_on)
    reset_mode = 1'b1;
    for (int k = 0; k < 8; k++) begin
      host.wr(8'h20, {cfei_mask_sel_t'(k), 5'h0a});
      `CHK("mask pick", cfei_mask_sel_t'(k), filter0_mask_pick)
    end
    rchk(8'h20, 8'hea, "f0 byte fields");
  endtask : t_lock

  task automatic t_match();
    host.wr(8'h70, 8'hfc);
    host.wr(8'h71, 8'h0f);
    host.wr(8'h72, 8'hff);
    host.wr(8'h73, 8'h0f);
    rchk(8'h73, 8'h0f, "extra enable");
    reset_mode = 1'b0;
    `CHK("filter on", 12'hffc, filter_on)
    pulse_hit(12'hffe);
    irq_chk(1'b0, "irq on match");
    host.wr(8'h74, 8'h00);
    host.wr(8'h75, 8'h00);
    rchk(8'h74, 8'hfc, "low flags");
    rchk(8'h74, 8'h00, "low flags cleared");
    irq_chk(1'b0, "irq held by high flags");
    rchk(8'h75, 8'h0f, "high flags");
    rchk(8'h75, 8'h00, "high flags cleared");
    irq_chk(1'b1, "irq released");
    host.wr(8'h72, 8'h00);
    host.wr(8'h73, 8'h00);
    pulse_hit(12'hffc);
    irq_chk(1'b1, "match irq disabled");
    rchk(8'h74, 8'hfc, "flags without enable");
    rchk(8'h75, 8'h0f, "extra flags no enable");
  endtask : t_match

  // Mask 2 ignores the two low identifier bits of the top byte.
  task automatic t_filter0();
    reset_mode = 1'b1;
    host.wr(8'h70, 8'h01);
    host.wr(8'h20, 8'h55);
    reset_mode = 1'b0;
    rx_id_hi = 5'h16;
    pulse_hit(12'h001);
    rchk(8'h74, 8'h01, "masked match");
    rx_id_hi = 5'h05;
    pulse_hit(12'h001);
    rchk(8'h74, 8'h00, "compared bit differs");
  endtask : t_filter0

  task automatic t_events();
    logic seen;
    seen = 1'b0;
    host.wr(8'h73, 8'hf0);
    stop_mode = 1'b1;
    wake_pin = 1'b1;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(negedge ref_clk);
      seen = stop_exit;
    end
    `CHK("stop exit", 1'b1, seen)
    if (!seen) complete_run();
    wake_pin = 1'b0;
    stop_mode = 1'b0;
    irq_chk(1'b0, "wake irq");
    rchk(8'h75, 8'h80, "wake flag");
    mem_corr_evt = 1'b1;
    @(negedge ref_clk);
    mem_corr_evt = 1'b0;
    irq_chk(1'b0, "mem irq");
    rchk(8'h75, 8'h20, "mem flag");
    thermal_sd = 1'b1;
    irq_chk(1'b0, "thermal irq");
    rchk(8'h75, 8'h10, "thermal entry");
    thermal_sd = 1'b0;
    rchk(8'h75, 8'h10, "thermal exit");
    xcvr_fault_pending = 1'b1;
    xcvr_err_evt = 1'b1;
    @(negedge ref_clk);
    xcvr_err_evt = 1'b0;
    irq_chk(1'b0, "xcvr irq");
    rchk(8'h75, 8'h40, "xcvr flag");
    rchk(8'h75, 8'h40, "xcvr flag sticky");
    xcvr_fault_pending = 1'b0;
    rchk(8'h75, 8'h00, "xcvr flag gone");
    irq_chk(1'b1, "irq idle");
  endtask : t_events

  task automatic t_wake_masked();
    host.wr(8'h73, 8'h00);
    wake_pin = 1'b1;
    repeat (2) @(negedge ref_clk);
    wake_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHK("wake irq masked", 1'b1, irq_out_low)
    rchk(8'h75, 8'h80, "wake flag no enable");
  endtask : t_wake_masked

  // The event lands in the very cycle of the clearing read.
  task automatic t_race();
    cfei_byte_t v;
    fork
      host.rd(8'h75, v);
      begin
        @(negedge ref_clk);
        mem_corr_evt = 1'b1;
        @(negedge ref_clk);
        mem_corr_evt = 1'b0;
      end
    join
    `CHK("race read", 8'h00, v)
    rchk(8'h75, 8'h20, "event kept");
  endtask : t_race

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    reset_mode = 1'b1;
    stop_mode = 1'b0;
    rx_hit = 12'h000;
    rx_id_hi = 5'h00;
    mask_hi_bank = 40'h00_0000_0c00;
    wake_pin = 1'b0;
    xcvr_err_evt = 1'b0;
    xcvr_fault_pending = 1'b0;
    mem_corr_evt = 1'b0;
    thermal_sd = 1'b0;
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    t_reset_vals();
    t_lock();
    t_match();
    t_filter0();
    t_events();
    t_wake_masked();
    t_race();
    complete_run();
  end
endmodule : cfei_top_tb

`undef CHK
`default_nettype wire
